//--- src/cbs_crossbar_switch_defines.vh
// constants for the crossbar switch: offsets, fields, resets, encodings
`ifndef CBS_CROSSBAR_SWITCH_DEFINES_VH
`define CBS_CROSSBAR_SWITCH_DEFINES_VH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define CBS_REG_AW 11
`define CBS_OFS_EXT_PRI 11'h100
`define CBS_OFS_EXT_CTL 11'h110
`define CBS_OFS_SRAM_PRI 11'h300
`define CBS_OFS_SRAM_CTL 11'h310
`define CBS_OFS_PERI_PRI 11'h700
`define CBS_OFS_PERI_CTL 11'h710

// ----------------------------------------------------------------
// slave port numbering
// ----------------------------------------------------------------
`define CBS_SLV_PERI 0
`define CBS_SLV_SRAM 1
`define CBS_SLV_EXT 2

// ----------------------------------------------------------------
// register fields and reset values
// ----------------------------------------------------------------
`define CBS_PRI_CORE_BIT 0
`define CBS_PRI_DMA_BIT 4
`define CBS_CTL_ARB_LO 8
`define CBS_CTL_ARB_HI 9
`define CBS_CTL_LOCK_BIT 31
`define CBS_PRI_CORE_RST 1'b0
`define CBS_PRI_DMA_RST 1'b1
`define CBS_ARB_RST 2'h0
`define CBS_LOCK_RST 1'b0

// ----------------------------------------------------------------
// encodings
// ----------------------------------------------------------------
`define CBS_ARB_FIXED 2'h0
`define CBS_ARB_RR 2'h1
`define CBS_SZ_BYTE 2'h0
`define CBS_SZ_HALF 2'h1
`define CBS_SZ_WORD 2'h2
`define CBS_SZ_LINE 2'h3
`define CBS_LINE_LAST_BEAT 2'h3
`define CBS_SINGLE_LAST_BEAT 2'h0
`define CBS_BEAT_GAP 2'h2
`define CBS_MST_CORE 1'b0
`define CBS_MST_DMA 1'b1

`endif

//--- src/cbs_crossbar_switch.v
// crossbar switch with per-slave arbiters and configuration registers
//
// Overview of operation
// - disjoint master/slave pairs proceed in parallel
// - built with three or two slave ports
// - 32-bit path: byte, half, word, line
// - one clock shared with the masters
// - each slave picks its own arbitration mode
// - fixed mode: masters hold distinct priority levels
// - fixed mode: highest requesting priority wins
// - a just-acked master is skipped for a cycle, so lower ones are not starved
// - round robin: port order first, then rotate
// - two registers per slave port
// - registers at the listed offsets
// - register access completes in two cycles
// - register access only in supervisor mode
// - only 32-bit accesses, others ignored
// - unimplemented location gives bus error
// - locked port: readable, writes get error
// - priority bits: dma bit 4, core bit 0
// - control bits 9:8 select arbitration mode
// - write lock sticky until reset
// - duplicate priority write rejected with error
`include "cbs_crossbar_switch_defines.vh"

module cbs_crossbar_switch #(
  parameter NUM_SLV = 3
) (
  // clock, reset, enable
  input wire clk_i,
  input wire rst_b_i,
  input wire ce_i,
  // master side, master 0 core, master 1 dma
  input wire [1:0] m_req_i,
  input wire [3:0] m_slv_i,
  input wire [1:0] m_write_i,
  input wire [3:0] m_size_i,
  input wire [63:0] m_addr_i,
  input wire [63:0] m_wdata_i,
  output reg [1:0] m_ack_o,
  output reg [63:0] m_rdata_o,
  // slave side
  output wire [NUM_SLV-1:0] s_req_o,
  output wire [NUM_SLV-1:0] s_mst_o,
  output wire [NUM_SLV-1:0] s_write_o,
  output wire [2*NUM_SLV-1:0] s_size_o,
  output wire [32*NUM_SLV-1:0] s_addr_o,
  output wire [32*NUM_SLV-1:0] s_wdata_o,
  input wire [NUM_SLV-1:0] s_ack_i,
  input wire [32*NUM_SLV-1:0] s_rdata_i,
  // peripheral register bus
  input wire reg_sel_i,
  input wire reg_write_i,
  input wire reg_super_i,
  input wire [1:0] reg_size_i,
  input wire [`CBS_REG_AW-1:0] reg_addr_i,
  input wire [31:0] reg_wdata_i,
  output reg reg_done_o,
  output reg reg_err_o,
  output reg [31:0] reg_rdata_o
);

  // ----------------------------------------------------------------
  // offset lookup per slave port
  // ----------------------------------------------------------------
  function [`CBS_REG_AW-1:0] pri_ofs;
    input integer s;
    begin
      case (s)
        `CBS_SLV_PERI: pri_ofs = `CBS_OFS_PERI_PRI;
        `CBS_SLV_SRAM: pri_ofs = `CBS_OFS_SRAM_PRI;
        default: pri_ofs = `CBS_OFS_EXT_PRI;
      endcase
    end
  endfunction

  function [`CBS_REG_AW-1:0] ctl_ofs;
    input integer s;
    begin
      case (s)
        `CBS_SLV_PERI: ctl_ofs = `CBS_OFS_PERI_CTL;
        `CBS_SLV_SRAM: ctl_ofs = `CBS_OFS_SRAM_CTL;
        default: ctl_ofs = `CBS_OFS_EXT_CTL;
      endcase
    end
  endfunction

  // ----------------------------------------------------------------
  // register access front end
  // ----------------------------------------------------------------
  reg rbusy_ff;
  reg lat_write_ff;
  reg lat_super_ff;
  reg [1:0] lat_size_ff;
  reg [`CBS_REG_AW-1:0] lat_addr_ff;
  reg [31:0] lat_wdata_ff;

  wire [NUM_SLV-1:0] hit_pri_v;
  wire [NUM_SLV-1:0] hit_ctl_v;
  wire [NUM_SLV-1:0] lock_v;
  wire [32*NUM_SLV-1:0] rval_v;
  wire lat_word = (lat_size_ff == `CBS_SZ_WORD);
  wire pri_dup = (lat_wdata_ff[`CBS_PRI_CORE_BIT] ==
                  lat_wdata_ff[`CBS_PRI_DMA_BIT]);
  wire exec = rbusy_ff;
  wire [1:0] m_ack_ff_w = m_ack_o;
  wire [2*NUM_SLV-1:0] ack_v;

  reg any_hit;
  reg bad_wr;
  reg [31:0] rd_sel;
  integer i;

  always @*
  begin
    any_hit = 1'b0;
    bad_wr = 1'b0;
    rd_sel = 32'h0;
    for (i = 0; i < NUM_SLV; i = i + 1)
    begin
      if (hit_pri_v[i] | hit_ctl_v[i])
      begin
        any_hit = 1'b1;
        rd_sel = rval_v[32*i +: 32];
        if (lock_v[i])
          bad_wr = 1'b1;
        if (hit_pri_v[i] & pri_dup)
          bad_wr = 1'b1;
      end
    end
  end

  // request taken on sel, answered at the second edge
  always @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      rbusy_ff <= 1'b0;
      lat_write_ff <= 1'b0;
      lat_super_ff <= 1'b0;
      lat_size_ff <= 2'h0;
      lat_addr_ff <= {`CBS_REG_AW{1'b0}};
      lat_wdata_ff <= 32'h0;
      reg_done_o <= 1'b0;
      reg_err_o <= 1'b0;
      reg_rdata_o <= 32'h0;
    end
    else if (ce_i)
    begin
      reg_done_o <= exec;
      reg_err_o <= 1'b0;
      reg_rdata_o <= 32'h0;
      if (reg_sel_i & ~rbusy_ff)
      begin
        rbusy_ff <= 1'b1;
        lat_write_ff <= reg_write_i;
        lat_super_ff <= reg_super_i;
        lat_size_ff <= reg_size_i;
        lat_addr_ff <= reg_addr_i;
        lat_wdata_ff <= reg_wdata_i;
      end
      else
        rbusy_ff <= 1'b0;
      if (exec)
      begin
        // user mode and holes both end in a bus error
        reg_err_o <= ~lat_super_ff | ~any_hit |
                     (lat_write_ff & lat_word & bad_wr);
        if (lat_super_ff & lat_word & ~lat_write_ff)
          reg_rdata_o <= rd_sel;
      end
    end
  end

  // ----------------------------------------------------------------
  // per slave port: registers and arbiter
  // ----------------------------------------------------------------
  genvar s;
  generate
    for (s = 0; s < NUM_SLV; s = s + 1)
    begin : g_slv
      reg pri_core_ff;
      reg pri_dma_ff;
      reg lock_ff;
      reg [1:0] arb_ff;
      reg busy_ff;
      reg own_ff;
      reg last_own_ff;
      reg req_ff;
      reg [1:0] beat_ff;
      reg [1:0] gap_ff;
      reg wr_ff;
      reg [1:0] sz_ff;
      reg [31:0] addr_ff;
      reg [31:0] wd_ff;

      wire hit_pri = (lat_addr_ff == pri_ofs(s));
      wire hit_ctl = (lat_addr_ff == ctl_ofs(s));
      wire wr_ok = exec & lat_write_ff & lat_super_ff & lat_word &
                   ~lock_ff;
      wire [1:0] want;
      wire both = &want;
      wire rr = (arb_ff == `CBS_ARB_RR);
      // unique levels make the core bit alone decide the winner
      wire pick = both ? (rr ? ~last_own_ff : pri_core_ff) : want[1];
      wire [1:0] last_beat = (sz_ff == `CBS_SZ_LINE) ?
                             `CBS_LINE_LAST_BEAT : `CBS_SINGLE_LAST_BEAT;
      wire beat_done = req_ff & s_ack_i[s];

      // a master just acked is skipped so its stale request is not reissued
      assign want[0] = m_req_i[0] & ~m_ack_ff_w[0] &
                       (m_slv_i[1:0] == s);
      assign want[1] = m_req_i[1] & ~m_ack_ff_w[1] &
                       (m_slv_i[3:2] == s);

      assign hit_pri_v[s] = hit_pri;
      assign hit_ctl_v[s] = hit_ctl;
      assign lock_v[s] = lock_ff;
      assign rval_v[32*s +: 32] = hit_pri ?
        (({31'h0, pri_core_ff} << `CBS_PRI_CORE_BIT) |
         ({31'h0, pri_dma_ff} << `CBS_PRI_DMA_BIT)) :
        (({31'h0, lock_ff} << `CBS_CTL_LOCK_BIT) |
         ({30'h0, arb_ff} << `CBS_CTL_ARB_LO));
      assign ack_v[2*s] = beat_done & (own_ff == `CBS_MST_CORE);
      assign ack_v[2*s+1] = beat_done & (own_ff == `CBS_MST_DMA);

      assign s_req_o[s] = req_ff;
      assign s_mst_o[s] = own_ff;
      assign s_write_o[s] = wr_ff;
      assign s_size_o[2*s +: 2] = sz_ff;
      assign s_addr_o[32*s +: 32] = addr_ff;
      assign s_wdata_o[32*s +: 32] = wd_ff;

      // configuration registers
      always @(posedge clk_i or negedge rst_b_i)
      begin
        if (!rst_b_i)
        begin
          pri_core_ff <= `CBS_PRI_CORE_RST;
          pri_dma_ff <= `CBS_PRI_DMA_RST;
          lock_ff <= `CBS_LOCK_RST;
          arb_ff <= `CBS_ARB_RST;
        end
        else if (ce_i)
        begin
          if (wr_ok & hit_pri & ~pri_dup)
          begin
            pri_core_ff <= lat_wdata_ff[`CBS_PRI_CORE_BIT];
            pri_dma_ff <= lat_wdata_ff[`CBS_PRI_DMA_BIT];
          end
          if (wr_ok & hit_ctl)
          begin
            arb_ff <= lat_wdata_ff[`CBS_CTL_ARB_HI:`CBS_CTL_ARB_LO];
            lock_ff <= lat_wdata_ff[`CBS_CTL_LOCK_BIT];
          end
        end
      end

      // arbiter and registered slave-side path
      always @(posedge clk_i or negedge rst_b_i)
      begin
        if (!rst_b_i)
        begin
          busy_ff <= 1'b0;
          own_ff <= `CBS_MST_CORE;
          last_own_ff <= `CBS_MST_DMA;
          req_ff <= 1'b0;
          beat_ff <= 2'h0;
          gap_ff <= 2'h0;
          wr_ff <= 1'b0;
          sz_ff <= `CBS_SZ_BYTE;
          addr_ff <= 32'h0;
          wd_ff <= 32'h0;
        end
        else if (ce_i)
        begin
          if (!busy_ff)
          begin
            if (|want)
            begin
              busy_ff <= 1'b1;
              own_ff <= pick;
              last_own_ff <= pick;
              req_ff <= 1'b1;
              beat_ff <= 2'h0;
              wr_ff <= m_write_i[pick];
              sz_ff <= m_size_i[2*pick +: 2];
              addr_ff <= m_addr_i[32*pick +: 32];
              wd_ff <= m_wdata_i[32*pick +: 32];
            end
          end
          else if (beat_done)
          begin
            req_ff <= 1'b0;
            if (beat_ff == last_beat)
              busy_ff <= 1'b0;
            else
            begin
              // wait for the master to present the next beat's data
              beat_ff <= beat_ff + 2'h1;
              gap_ff <= `CBS_BEAT_GAP;
            end
          end
          else if (gap_ff != 2'h0)
          begin
            gap_ff <= gap_ff - 2'h1;
            if (gap_ff == 2'h1)
            begin
              req_ff <= 1'b1;
              wd_ff <= m_wdata_i[32*own_ff +: 32];
            end
          end
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // master-side answers
  // ----------------------------------------------------------------
  reg [1:0] nxt_ack;
  reg [63:0] nxt_rdata;
  integer k;

  always @*
  begin
    nxt_ack = 2'h0;
    nxt_rdata = 64'h0;
    for (k = 0; k < NUM_SLV; k = k + 1)
    begin
      if (ack_v[2*k])
      begin
        nxt_ack[0] = 1'b1;
        nxt_rdata[31:0] = s_rdata_i[32*k +: 32];
      end
      if (ack_v[2*k+1])
      begin
        nxt_ack[1] = 1'b1;
        nxt_rdata[63:32] = s_rdata_i[32*k +: 32];
      end
    end
  end

  always @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      m_ack_o <= 2'h0;
      m_rdata_o <= 64'h0;
    end
    else if (ce_i)
    begin
      m_ack_o <= nxt_ack;
      m_rdata_o <= nxt_rdata;
    end
  end

endmodule

//--- test/cbs_xbar_checker.sv
// port-level assertions for the crossbar switch
module cbs_xbar_checker #(
  parameter NUM_SLV = 3
) (
  // clock and reset
  input wire clk_i,
  input wire rst_b_i,
  // master side
  input wire [1:0] m_req_i,
  input wire [1:0] m_ack_o,
  // slave side
  input wire [NUM_SLV-1:0] s_req_o,
  input wire [NUM_SLV-1:0] s_mst_o,
  input wire [NUM_SLV-1:0] s_ack_i,
  // register bus
  input wire reg_sel_i,
  input wire reg_super_i,
  input wire [1:0] reg_size_i,
  input wire reg_done_o,
  input wire reg_err_o,
  input wire [31:0] reg_rdata_o
);
  // ------------------------------------------------------------
  // register bus
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_b_i);
  a_done_two_cyc: assert property (reg_done_o |-> $past(reg_sel_i, 2))
    else $error("register answer without request two cycles before");
  a_done_one_pulse: assert property (reg_done_o |=> !reg_done_o)
    else $error("register answer longer than one cycle");
  a_user_err: assert property (reg_sel_i && !reg_super_i
    |-> ##2 reg_done_o && reg_err_o) else $error("user access not refused");
  a_err_with_done: assert property (reg_err_o |-> reg_done_o)
    else $error("bus error outside answer cycle");
  a_narrow_zero: assert property (reg_sel_i && reg_size_i != 2'h2
    |-> ##2 reg_rdata_o == 32'h0) else $error("narrow access returned data");
  // ------------------------------------------------------------
  // sram slave path and dma master acknowledge
  // ------------------------------------------------------------
  a_req_held: assert property (s_req_o[1] && !s_ack_i[1] |=> s_req_o[1])
    else $error("slave request dropped before acknowledge");
  a_ack_routed: assert property (s_req_o[1] && s_ack_i[1]
    |=> m_ack_o[$past(s_mst_o[1])] && !s_req_o[1])
    else $error("slave acknowledge not passed to owner");
  a_grant_requested: assert property ($rose(s_req_o[1])
    |-> (($past(m_req_i) & (2'h1 << s_mst_o[1])) != 2'h0))
    else $error("slave granted to idle master");
  a_beat_pulse: assert property (m_ack_o[1] |=> !m_ack_o[1])
    else $error("master acknowledge longer than one cycle");
endmodule

//--- test/cbs_slave_model.sv
// behavioural memory slaves answering every slave port
module cbs_slave_model #(
  parameter N = 3,
  parameter logic [31:0] KEY = 32'h5a5a_5a5a
) (
  // clock and reset
  input wire clk_i,
  input wire rst_b_i,
  // two extra wait cycles when high
  input wire slow_i,
  // slave ports
  input wire [N-1:0] s_req_i,
  input wire [32*N-1:0] s_addr_i,
  output logic [N-1:0] s_ack_o,
  output logic [32*N-1:0] s_rdata_o
);
  logic [1:0] wait_ff [N];
  // data toggles outside the ack cycle so stale values never match
  always @(posedge clk_i or negedge rst_b_i)
  begin
    for (int k = 0; k < N; k++)
    begin
      if (!rst_b_i)
      begin
        s_ack_o[k] <= 1'b0;
        wait_ff[k] <= 2'h0;
        s_rdata_o[32*k +: 32] <= 32'h0;
      end
      else if (s_req_i[k] && !s_ack_o[k] && wait_ff[k] >= {slow_i, 1'b0})
      begin
        s_ack_o[k] <= 1'b1;
        wait_ff[k] <= 2'h0;
        s_rdata_o[32*k +: 32] <= s_addr_i[32*k +: 32] ^ KEY;
      end
      else
      begin
        s_ack_o[k] <= 1'b0;
        wait_ff[k] <= wait_ff[k] + {1'b0, s_req_i[k] & ~s_ack_o[k]};
        s_rdata_o[32*k +: 32] <= ~s_rdata_o[32*k +: 32];
      end
    end
  end
endmodule

//--- test/cbs_crossbar_switch_tb.sv
// self-checking bench for the crossbar switch
module cbs_crossbar_switch_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [31:0] KEY = 32'h5a5a_5a5a;
  localparam logic [10:0] OFS [6] = '{11'h100, 11'h110, 11'h300,
    11'h310, 11'h700, 11'h710};
  logic clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic ce_i = 1'b1;
  logic slow = 1'b0;
  logic [1:0] m_req_i = 2'h0;
  logic [3:0] m_slv_i = 4'h0;
  logic [1:0] m_write_i = 2'h0;
  logic [3:0] m_size_i = 4'h0;
  logic [63:0] m_addr_i = 64'h0;
  logic [63:0] m_wdata_i = 64'h0;
  logic [1:0] m_ack_o;
  logic [63:0] m_rdata_o;
  logic [2:0] s_req_o, s_mst_o, s_write_o, s_ack_i;
  logic [5:0] s_size_o;
  logic [95:0] s_addr_o, s_wdata_o, s_rdata_i;
  logic reg_sel_i = 1'b0, reg_write_i = 1'b0, reg_super_i = 1'b1;
  logic [1:0] reg_size_i = 2'h2;
  logic [10:0] reg_addr_i = 11'h0;
  logic [31:0] reg_wdata_i = 32'h0, reg_rdata_o;
  logic reg_done_o, reg_err_o;
  int error_cnt = 0, n_checks = 0;
  bit order[$];
  always #20 clk_i = ~clk_i;
  cbs_crossbar_switch cbs_crossbar_switch_i (.*);
  cbs_slave_model cbs_slave_model_i (.clk_i(clk_i), .rst_b_i(rst_b_i),
    .slow_i(slow), .s_req_i(s_req_o), .s_addr_i(s_addr_o),
    .s_ack_o(s_ack_i), .s_rdata_o(s_rdata_i));
  // ------------------------------------------------------------
  // checking and closing
  // ------------------------------------------------------------
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, g);
    n_checks++;
    if (g !== e)
    begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic stall(input logic ok);
    if (!ok)
    begin
      error_cnt++;
      wrap_up();
    end
  endtask
  // ------------------------------------------------------------
  // bus tasks; md is {write, supervisor}
  // ------------------------------------------------------------
  task automatic racc(input logic [1:0] md, z, input logic [10:0] a,
    input logic [31:0] d, input logic xe, input logic [31:0] xr);
    @(negedge clk_i);
    {reg_sel_i, reg_write_i, reg_super_i} = {1'b1, md};
    {reg_size_i, reg_addr_i, reg_wdata_i} = {z, a, d};
    @(negedge clk_i);
    reg_sel_i = 1'b0;
    for (int i = 0; i < 4 && reg_done_o !== 1'b1; i++)
      @(negedge clk_i);
    stall(reg_done_o === 1'b1);
    chk("reg_err_o", {31'h0, xe}, {31'h0, reg_err_o});
    if (!md[1])
      chk("reg_rdata_o", xr, reg_rdata_o);
  endtask
  task automatic mread(input int m, input logic [1:0] sl, z,
    input logic [31:0] a);
    int n;
    n = (z == 2'h3) ? 4 : 1;
    @(negedge clk_i);
    m_slv_i[2*m +: 2] = sl;
    m_size_i[2*m +: 2] = z;
    m_addr_i[32*m +: 32] = a;
    m_req_i[m] = 1'b1;
    for (int b = 0; b < n; b++)
    begin
      for (int i = 0; i < 60 && m_ack_o[m] !== 1'b1; i++)
        @(negedge clk_i);
      stall(m_ack_o[m] === 1'b1);
      order.push_back(m[0]);
      chk("m_rdata_o", a ^ KEY, m_rdata_o[32*m +: 32]);
      if (b < n - 1)
        @(negedge clk_i);
    end
    m_req_i[m] = 1'b0;
  endtask
  // core alone, then both masters race for sram with line bursts
  task automatic race(input bit first);
    mread(0, 2'h1, 2'h2, 32'h40);
    order.delete();
    fork
      mread(0, 2'h1, 2'h3, 32'h100);
      mread(1, 2'h1, 2'h3, 32'h200);
    join
    chk("first grant", {31'h0, first}, {31'h0, order[0]});
    chk("burst owner", {31'h0, first}, {31'h0, order[3]});
  endtask
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial
  begin
    repeat (8) @(negedge clk_i);
    rst_b_i = 1'b1;
    foreach (OFS[k])
      racc(2'h1, 2'h2, OFS[k], 0, 0, OFS[k][4] ? 32'h0 : 32'h10);
    racc(2'h1, 2'h2, 11'h104, 0, 1, 0);
    racc(2'h0, 2'h2, 11'h300, 0, 1, 0);
    racc(2'h3, 2'h0, 11'h300, 32'h1, 0, 0);
    racc(2'h1, 2'h1, 11'h300, 0, 0, 0);
    racc(2'h3, 2'h2, 11'h300, 32'h11, 1, 0);
    racc(2'h1, 2'h2, 11'h300, 0, 0, 32'h10);
    slow = 1'b1;
    race(1'b0);
    racc(2'h3, 2'h2, 11'h300, 32'h1, 0, 0);
    race(1'b1);
    racc(2'h3, 2'h2, 11'h300, 32'h10, 0, 0);
    racc(2'h3, 2'h2, 11'h310, 32'h100, 0, 0);
    race(1'b1);
    slow = 1'b0;
    fork
      mread(0, 2'h0, 2'h2, 32'h8);
      mread(1, 2'h2, 2'h0, 32'h31);
    join
    chk("s_addr_o", 32'h31, s_addr_o[95:64]);
    chk("s_size_o", 32'h0, {30'h0, s_size_o[5:4]});
    chk("s_write_o", 32'h0, {31'h0, s_write_o[2]});
    chk("s_mst_o", 32'h1, {31'h0, s_mst_o[2]});
    racc(2'h3, 2'h2, 11'h710, 32'h8000_0000, 0, 0);
    racc(2'h3, 2'h2, 11'h700, 32'h1, 1, 0);
    racc(2'h1, 2'h2, 11'h700, 0, 0, 32'h10);
    racc(2'h3, 2'h2, 11'h710, 32'h0, 1, 0);
    racc(2'h1, 2'h2, 11'h710, 0, 0, 32'h8000_0000);
    @(negedge clk_i);
    rst_b_i = 1'b0;
    @(negedge clk_i);
    rst_b_i = 1'b1;
    racc(2'h1, 2'h2, 11'h710, 0, 0, 0);
    wrap_up();
  end
endmodule

bind cbs_crossbar_switch cbs_xbar_checker #(.NUM_SLV(NUM_SLV))
  cbs_xbar_checker_i (.*);
